//--- hdl/ccr_regs.v
// charge configuration register slice: two-wire serial slave, register
// file at 02..06 and 11 hex, temperature band selection and fault
// assumes: scl/sda and analog comparator levels arrive asynchronously
`timescale 1ns/10ps
`include "ccr_defs.vh"

module ccr_regs #(
    parameter [6:0] DEV_ADDR = 7'h2A  // arbitrary bus address
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // serial program interface, open drain data
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    // analog comparator levels
    input  wire        temp_below_0,
    input  wire        temp_above_60,
    input  wire [1:0]  temp_band,
    input  wire        vbat_ge_3v0,
    // charge control outputs
    output reg         charge_enable,
    output reg         temp_fault,
    output reg  [10:0] band_current_ma,
    output reg  [10:0] output_limit_ma,
    output reg  [2:0]  vterm_code,
    output reg  [12:0] vterm_mv,
    output reg         vterm_invalid
);

    // serial slave states
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_ADDR  = 4'h1;
    localparam [3:0] ST_AACK  = 4'h2;
    localparam [3:0] ST_REG   = 4'h3;
    localparam [3:0] ST_RACK  = 4'h4;
    localparam [3:0] ST_WDAT  = 4'h5;
    localparam [3:0] ST_WACK  = 4'h6;
    localparam [3:0] ST_RDAT  = 4'h7;
    localparam [3:0] ST_MACK  = 4'h8;

    // synchronisers: first stage, second stage, edge copy
    reg [1:0] scl_s1, sda_s1;
    reg [1:0] scl_s2, sda_s2;
    reg [4:0] ana_s1, ana_s2;
    wire      scl_rise = scl_s2[0] & ~scl_s2[1];
    wire      scl_fall = ~scl_s2[0] & scl_s2[1];
    wire      start_c  = scl_s2[0] & scl_s2[1] & ~sda_s2[0] & sda_s2[1];
    wire      stop_c   = scl_s2[0] & scl_s2[1] & sda_s2[0] & ~sda_s2[1];
    wire      sda_now  = sda_s2[0];

    // register file
    reg [7:0] vterm_cool_nom, vterm_warm_hot;
    reg [7:0] curr_cool_nom, curr_warm_hot, timers;
    reg       en_cfg;

    // slave state
    reg [3:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [7:0] ptr;
    reg [7:0] rd_byte;
    reg       rd_mode;
    reg       master_nack;

    // offsets 02..06 are gated by the enable bit
    function gated;
        input [7:0] a;
        begin
            gated = (a >= `CCR_OFS_VTERM_COOL_NOM) && (a <= `CCR_OFS_TIMERS);
        end
    endfunction

    // read multiplexer; gated registers read zero while access is off
    function [7:0] reg_read;
        input [7:0] a;
        begin
            reg_read = 8'h00;
            if (a == `CCR_OFS_CFG_ENABLE)
                reg_read = {7'h00, en_cfg};
            else if (en_cfg && gated(a)) begin
                case (a)
                    `CCR_OFS_VTERM_COOL_NOM: reg_read = vterm_cool_nom;
                    `CCR_OFS_VTERM_WARM_HOT: reg_read = vterm_warm_hot;
                    `CCR_OFS_CURR_COOL_NOM:  reg_read = curr_cool_nom;
                    `CCR_OFS_CURR_WARM_HOT:  reg_read = curr_warm_hot;
                    default:                 reg_read = timers;
                endcase
            end
        end
    endfunction

    // read data for the current pointer, bit 7 goes out first
    wire [7:0] rd_next = reg_read(ptr);

    // three flip-flops on scl and sda plus one edge copy, two flip-flops on the analog levels
    always @(posedge ref_clk) begin
        if (rst) begin
            scl_s1 <= 2'h3;
            sda_s1 <= 2'h3;
            scl_s2 <= 2'h3;
            sda_s2 <= 2'h3;
            ana_s1 <= 5'h00;
            ana_s2 <= 5'h00;
        end else begin
            scl_s1 <= {scl_s1[0], scl_in};
            sda_s1 <= {sda_s1[0], sda_in};
            scl_s2 <= {scl_s2[0], scl_s1[1]};
            sda_s2 <= {sda_s2[0], sda_s1[1]};
            ana_s1 <= {temp_below_0, temp_above_60, temp_band, vbat_ge_3v0};
            ana_s2 <= ana_s1;
        end
    end

    // serial slave: sample on scl rise, drive on scl fall
    always @(posedge ref_clk) begin
        if (rst) begin
            state          <= ST_IDLE;
            bit_cnt        <= 4'h0;
            shift          <= 8'h00;
            ptr            <= 8'h00;
            rd_byte        <= 8'h00;
            rd_mode        <= 1'b0;
            master_nack    <= 1'b0;
            sda_out        <= 1'b0;
            sda_oe         <= 1'b0;
            vterm_cool_nom <= `CCR_RST_CFG;
            vterm_warm_hot <= `CCR_RST_CFG;
            curr_cool_nom  <= `CCR_RST_CFG;
            curr_warm_hot  <= `CCR_RST_CFG;
            timers         <= `CCR_RST_CFG;
            en_cfg         <= `CCR_RST_CFG_ENABLE;
        end else if (start_c) begin
            state   <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
        end else if (stop_c) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            case (state)
                ST_ADDR, ST_REG, ST_WDAT: begin
                    shift   <= {shift[6:0], sda_now};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                ST_RDAT: bit_cnt <= bit_cnt + 4'h1;
                ST_MACK: begin
                    master_nack <= sda_now;
                    if (!sda_now)
                        ptr <= ptr + 8'h01;
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: if (bit_cnt == 4'h8) begin
                    if (shift[7:1] == DEV_ADDR) begin
                        sda_oe  <= 1'b1;
                        rd_mode <= shift[0];
                        state   <= ST_AACK;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_AACK: begin
                    bit_cnt <= 4'h0;
                    if (rd_mode) begin
                        rd_byte <= rd_next;
                        sda_oe  <= ~rd_next[7];
                        state   <= ST_RDAT;
                    end else begin
                        sda_oe <= 1'b0;
                        state  <= ST_REG;
                    end
                end
                ST_REG: if (bit_cnt == 4'h8) begin
                    ptr    <= shift;
                    sda_oe <= 1'b1;
                    state  <= ST_RACK;
                end
                ST_RACK, ST_WACK: begin
                    sda_oe  <= 1'b0;
                    bit_cnt <= 4'h0;
                    state   <= ST_WDAT;
                end
                ST_WDAT: if (bit_cnt == 4'h8) begin
                    // writes to 02..06 dropped while access is disabled
                    if (ptr == `CCR_OFS_CFG_ENABLE)
                        en_cfg <= shift[`CCR_EN_CFG_BIT];
                    else if (en_cfg) begin
                        case (ptr)
                            `CCR_OFS_VTERM_COOL_NOM: vterm_cool_nom <= shift;
                            `CCR_OFS_VTERM_WARM_HOT: vterm_warm_hot <= shift;
                            `CCR_OFS_CURR_COOL_NOM:  curr_cool_nom  <= shift;
                            `CCR_OFS_CURR_WARM_HOT:  curr_warm_hot  <= shift;
                            `CCR_OFS_TIMERS:         timers         <= shift;
                            default: ;
                        endcase
                    end
                    ptr    <= ptr + 8'h01;
                    sda_oe <= 1'b1;
                    state  <= ST_WACK;
                end
                ST_RDAT: begin
                    if (bit_cnt == 4'h8) begin
                        sda_oe <= 1'b0;
                        state  <= ST_MACK;
                    end else begin
                        sda_oe <= ~rd_byte[3'h7 - bit_cnt[2:0]];
                    end
                end
                ST_MACK: begin
                    bit_cnt <= 4'h0;
                    if (master_nack) begin
                        sda_oe <= 1'b0;
                        state  <= ST_IDLE;
                    end else begin
                        rd_byte <= rd_next;
                        sda_oe  <= ~rd_next[7];
                        state   <= ST_RDAT;
                    end
                end
                default: ;
            endcase
        end
    end

    // field selection for the measured band
    wire [10:0] dec_band_ma;
    wire [10:0] dec_limit_ma;
    wire [2:0]  dec_vt_code;
    wire [12:0] dec_vt_mv;
    wire        dec_vt_inv;

    ccr_decode u_decode (
        .band            (ana_s2[2:1]),
        .vterm_cool_nom  (vterm_cool_nom),
        .vterm_warm_hot  (vterm_warm_hot),
        .curr_cool_nom   (curr_cool_nom),
        .curr_warm_hot   (curr_warm_hot),
        .vbat_ge_3v0     (ana_s2[0]),
        .band_current_ma (dec_band_ma),
        .vterm_code      (dec_vt_code),
        .vterm_mv        (dec_vt_mv),
        .vterm_invalid   (dec_vt_inv),
        .output_limit_ma (dec_limit_ma)
    );

    // register the control outputs; follow band changes every cycle
    always @(posedge ref_clk) begin
        if (rst) begin
            charge_enable   <= 1'b0;
            temp_fault      <= 1'b0;
            band_current_ma <= 11'h000;
            output_limit_ma <= 11'h000;
            vterm_code      <= 3'h0;
            vterm_mv        <= 13'h0000;
            vterm_invalid   <= 1'b0;
        end else begin
            temp_fault      <= ana_s2[4] | ana_s2[3];
            charge_enable   <= ~(ana_s2[4] | ana_s2[3]);
            band_current_ma <= dec_band_ma;
            output_limit_ma <= dec_limit_ma;
            vterm_code      <= dec_vt_code;
            vterm_mv        <= dec_vt_mv;
            vterm_invalid   <= dec_vt_inv;
        end
    end

endmodule // ccr_regs

//--- hdl/ccr_defs.vh
// register offsets, field positions, reset values and encodings of the
// charge configuration register slice; definitions only
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// register offsets on the serial program interface
`define CCR_OFS_VTERM_COOL_NOM  8'h02
`define CCR_OFS_VTERM_WARM_HOT  8'h03
`define CCR_OFS_CURR_COOL_NOM   8'h04
`define CCR_OFS_CURR_WARM_HOT   8'h05
`define CCR_OFS_TIMERS          8'h06
`define CCR_OFS_CFG_ENABLE      8'h11

// reset values
`define CCR_RST_CFG             8'h00
`define CCR_RST_CFG_ENABLE      1'h0

// field positions, high nibble / low nibble and 2+3+3 layout
`define CCR_CURR_HI_MSB         7
`define CCR_CURR_HI_LSB         4
`define CCR_CURR_LO_MSB         3
`define CCR_CURR_LO_LSB         0
`define CCR_SMALL_MSB           7
`define CCR_SMALL_LSB           6
`define CCR_VT_HI_MSB           5
`define CCR_VT_HI_LSB           3
`define CCR_VT_LO_MSB           2
`define CCR_VT_LO_LSB           0
`define CCR_EN_CFG_BIT          0

// temperature band codes
`define CCR_BAND_COLD           2'h0
`define CCR_BAND_NOMINAL        2'h1
`define CCR_BAND_WARM           2'h2
`define CCR_BAND_HOT            2'h3

// current encodings in mA
`define CCR_CURR_CODE0_MA       11'h032
`define CCR_CURR_STEP_MA        11'h064
`define CCR_SMALL_MA_0          11'h032
`define CCR_SMALL_MA_1          11'h064
`define CCR_SMALL_MA_2          11'h0B9
`define CCR_SMALL_MA_3          11'h172

// termination voltage encodings in mV, invalid code reads 0
`define CCR_VT_MV_0             13'h0F64
`define CCR_VT_MV_1             13'h0FA0
`define CCR_VT_MV_2             13'h0FD2
`define CCR_VT_MV_3             13'h1004
`define CCR_VT_MV_4             13'h1018
`define CCR_VT_MV_5             13'h1036
`define CCR_VT_MV_6             13'h1054
`define CCR_VT_INVALID          3'h7

`endif

//--- hdl/ccr_decode.v
// field selection and decoding for the charge configuration slice
// assumes: purely combinational, outputs registered by the caller
`timescale 1ns/10ps
`include "ccr_defs.vh"

module ccr_decode (
    // temperature band, register contents and battery level
    input  wire [1:0]  band,
    input  wire [7:0]  vterm_cool_nom,
    input  wire [7:0]  vterm_warm_hot,
    input  wire [7:0]  curr_cool_nom,
    input  wire [7:0]  curr_warm_hot,
    input  wire        vbat_ge_3v0,
    // decoded values
    output reg  [10:0] band_current_ma,
    output reg  [2:0]  vterm_code,
    output wire [12:0] vterm_mv,
    output wire        vterm_invalid,
    output wire [10:0] output_limit_ma
);

    // 4-bit current limit: 0 -> 50 mA, N -> N x 100 mA
    function [10:0] curr_ma;
        input [3:0] code;
        begin
            if (code == 4'h0)
                curr_ma = `CCR_CURR_CODE0_MA;
            else
                curr_ma = {7'h00, code} * `CCR_CURR_STEP_MA;
        end
    endfunction

    // 2-bit pre-charge / end-of-charge current
    function [10:0] small_ma;
        input [1:0] code;
        begin
            case (code)
                2'h0:    small_ma = `CCR_SMALL_MA_0;
                2'h1:    small_ma = `CCR_SMALL_MA_1;
                2'h2:    small_ma = `CCR_SMALL_MA_2;
                default: small_ma = `CCR_SMALL_MA_3;
            endcase
        end
    endfunction

    // 3-bit termination voltage, code 7 invalid
    function [12:0] vt_mv;
        input [2:0] code;
        begin
            case (code)
                3'h0:    vt_mv = `CCR_VT_MV_0;
                3'h1:    vt_mv = `CCR_VT_MV_1;
                3'h2:    vt_mv = `CCR_VT_MV_2;
                3'h3:    vt_mv = `CCR_VT_MV_3;
                3'h4:    vt_mv = `CCR_VT_MV_4;
                3'h5:    vt_mv = `CCR_VT_MV_5;
                3'h6:    vt_mv = `CCR_VT_MV_6;
                default: vt_mv = 13'h0000;
            endcase
        end
    endfunction

    // pick the fields of the measured band
    always @* begin
        case (band)
            `CCR_BAND_COLD: begin
                band_current_ma = curr_ma(curr_cool_nom[`CCR_CURR_HI_MSB:`CCR_CURR_HI_LSB]);
                vterm_code      = vterm_cool_nom[`CCR_VT_HI_MSB:`CCR_VT_HI_LSB];
            end
            `CCR_BAND_NOMINAL: begin
                band_current_ma = curr_ma(curr_cool_nom[`CCR_CURR_LO_MSB:`CCR_CURR_LO_LSB]);
                vterm_code      = vterm_cool_nom[`CCR_VT_LO_MSB:`CCR_VT_LO_LSB];
            end
            `CCR_BAND_WARM: begin
                band_current_ma = curr_ma(curr_warm_hot[`CCR_CURR_HI_MSB:`CCR_CURR_HI_LSB]);
                vterm_code      = vterm_warm_hot[`CCR_VT_HI_MSB:`CCR_VT_HI_LSB];
            end
            default: begin
                band_current_ma = curr_ma(curr_warm_hot[`CCR_CURR_LO_MSB:`CCR_CURR_LO_LSB]);
                vterm_code      = vterm_warm_hot[`CCR_VT_LO_MSB:`CCR_VT_LO_LSB];
            end
        endcase
    end

    assign vterm_mv      = vt_mv(vterm_code);
    assign vterm_invalid = (vterm_code == `CCR_VT_INVALID);
    // end-of-charge limit at or above 3.0 V, pre-charge limit below
    assign output_limit_ma = vbat_ge_3v0 ?
        small_ma(vterm_warm_hot[`CCR_SMALL_MSB:`CCR_SMALL_LSB]) :
        small_ma(vterm_cool_nom[`CCR_SMALL_MSB:`CCR_SMALL_LSB]);

endmodule // ccr_decode

//--- tb/ccr_host.sv
// host model: bit-level master of the two-wire program bus
// assumes: bench resolves the open-drain data wire with a pull-up
`timescale 1ns/10ps
module ccr_host #(
    parameter [6:0] DEV = 7'h2A  // arbitrary bus address
) (
    // clock and bus
    input  wire ref_clk,
    input  wire sda_in,
    output reg  scl,
    output reg  sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // step n clocks, then move off the edge
    task automatic q(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // one bit period; 5-clock phases clear the 3-clock sync lag
    task automatic bio(input logic b, output logic r);
        q(5);
        sda_pull = !b;
        q(5);
        scl = 1'b1;
        q(5);
        r = sda_in;
        scl = 1'b0;
    endtask
    // eight bits msb first plus the ninth slot
    task automatic xb(input [7:0] d, input logic nine, output [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            bio(d[i], r[i]);
        bio(nine, a);
    endtask
    // start or repeated start, scl left low
    task automatic st;
        q(5);
        sda_pull = 1'b0;
        q(5);
        scl = 1'b1;
        q(5);
        sda_pull = 1'b1;
        q(5);
        scl = 1'b0;
    endtask
    // stop condition, bus left idle
    task automatic sp;
        q(5);
        sda_pull = 1'b1;
        q(5);
        scl = 1'b1;
        q(5);
        sda_pull = 1'b0;
        q(5);
    endtask
    // register write; ok when all three bytes were acknowledged
    task automatic wr(input [6:0] dev, input [7:0] ra, input [7:0] d, output logic ok);
        logic [7:0] r;
        logic a0, a1, a2;
        st();
        xb({dev, 1'b0}, 1'b1, r, a0);
        xb(ra, 1'b1, r, a1);
        xb(d, 1'b1, r, a2);
        sp();
        ok = !(a0 | a1 | a2);
    endtask
    // register read: pointer write, repeated start, one byte with nack
    task automatic rd(input [7:0] ra, output [7:0] d);
        logic [7:0] r;
        logic k;
        st();
        xb({DEV, 1'b0}, 1'b1, r, k);
        xb(ra, 1'b1, r, k);
        st();
        xb({DEV, 1'b1}, 1'b1, r, k);
        xb(8'hFF, 1'b1, d, k);
        sp();
    endtask
    // two-byte read: master acks the first byte, pointer steps on
    task automatic rd2(input [7:0] ra, output [7:0] d0, output [7:0] d1);
        logic [7:0] r;
        logic k;
        st();
        xb({DEV, 1'b0}, 1'b1, r, k);
        xb(ra, 1'b1, r, k);
        st();
        xb({DEV, 1'b1}, 1'b1, r, k);
        xb(8'hFF, 1'b0, d0, k);
        xb(8'hFF, 1'b1, d1, k);
        sp();
    endtask
endmodule // ccr_host

//--- tb/ccr_regs_asserts.sv
// checker for the charge configuration slice, sees top ports only
// assumes: single clock, synchronous active-high reset
`timescale 1ns/10ps
module ccr_regs_asserts (
    // clock, reset, bus
    input wire        ref_clk,
    input wire        rst,
    input wire        scl_in,
    input wire        sda_in,
    input wire        sda_out,
    input wire        sda_oe,
    // analog levels
    input wire        temp_below_0,
    input wire        temp_above_60,
    input wire [1:0]  temp_band,
    input wire        vbat_ge_3v0,
    // charge control
    input wire        charge_enable,
    input wire        temp_fault,
    input wire [10:0] band_current_ma,
    input wire [10:0] output_limit_ma,
    input wire [2:0]  vterm_code,
    input wire [12:0] vterm_mv,
    input wire        vterm_invalid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    reg [2:0] alive;
    // edges since reset release, saturating; syncs flushed at 4
    always @(posedge ref_clk)
        if (rst)
            alive <= 3'h0;
        else if (alive != 3'h4)
            alive <= alive + 3'h1;
    // termination voltage table in mV
    function automatic [12:0] mv(input [2:0] c);
        case (c)
            3'h0: mv = 13'h0F64;
            3'h1: mv = 13'h0FA0;
            3'h2: mv = 13'h0FD2;
            3'h3: mv = 13'h1004;
            3'h4: mv = 13'h1018;
            3'h5: mv = 13'h1036;
            3'h6: mv = 13'h1054;
            default: mv = 13'h0000;
        endcase
    endfunction
    chk_fault_follow:
    assert property (alive == 3'h4 |-> temp_fault == $past(temp_below_0 | temp_above_60, 3))
        else $error("fault flag off its temperature cause");
    chk_charge_stop:
    assert property (alive == 3'h4 |-> charge_enable == !$past(temp_below_0 | temp_above_60, 3))
        else $error("charge enable off its temperature cause");
    chk_current_grid:
    assert property (alive == 3'h4 |-> band_current_ma == 11'h032 || (band_current_ma % 100 == 0
        && band_current_ma >= 11'h064 && band_current_ma <= 11'h5DC))
        else $error("band current outside the code grid");
    chk_limit_set:
    assert property (alive == 3'h4 |-> output_limit_ma inside {11'h032, 11'h064, 11'h0B9, 11'h172})
        else $error("output limit not a small-current setting");
    chk_invalid_code:
    assert property (alive == 3'h4 |-> vterm_invalid == (vterm_code == 3'h7))
        else $error("invalid flag disagrees with code");
    chk_mv_table:
    assert property (alive == 3'h4 |-> vterm_mv == mv(vterm_code))
        else $error("termination mV disagrees with code");
    chk_hold_steady:
    assert property ((alive == 3'h4 && $stable(temp_band) && $stable(scl_in) && $stable(vbat_ge_3v0))[*6]
        |=> $stable({band_current_ma, vterm_code, output_limit_ma}))
        else $error("band outputs moved without a cause");
    chk_ack_scl_low:
    assert property ($rose(sda_oe) |-> !$past(scl_in, 3))
        else $error("data driven while clock high");
    chk_reset_quiet:
    assert property (disable iff (1'b0) rst |=> !sda_oe && !charge_enable && !temp_fault)
        else $error("outputs active during reset");
    chk_drain_only:
    assert property (!sda_out && (!sda_oe || !sda_in))
        else $error("data pin not driven as open drain");
    cov_fault: cover property ($rose(temp_fault));
    cov_ack: cover property ($rose(sda_oe));
    cov_invalid: cover property ($rose(vterm_invalid));
endmodule // ccr_regs_asserts
bind ccr_regs ccr_regs_asserts u_chk (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .temp_below_0(temp_below_0), .temp_above_60(temp_above_60),
    .temp_band(temp_band), .vbat_ge_3v0(vbat_ge_3v0), .charge_enable(charge_enable),
    .temp_fault(temp_fault), .band_current_ma(band_current_ma),
    .output_limit_ma(output_limit_ma), .vterm_code(vterm_code), .vterm_mv(vterm_mv),
    .vterm_invalid(vterm_invalid)
);

//--- tb/charge_current_config_regs_tb_top.sv
// testbench for the charge configuration slice
// assumes: host model drives the bus; bench drives the analog levels
`timescale 1ns/10ps
module charge_current_config_regs_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic temp_below_0 = 1'b0;
    logic temp_above_60 = 1'b0;
    logic [1:0] temp_band = 2'h1;
    logic vbat_ge_3v0 = 1'b0;
    wire scl, pull, sda_oe, sda_out, charge_enable, temp_fault, vterm_invalid;
    wire [10:0] band_current_ma, output_limit_ma;
    wire [2:0] vterm_code;
    wire [12:0] vterm_mv;
    wire sda = !(pull | sda_oe);
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    logic ok;
    logic [7:0] d, d2;
    logic [15:0] cur[4] = '{16'h03E8, 16'h01F4, 16'h012C, 16'h04B0};
    logic [15:0] vt[4] = '{16'h1036, 16'h1054, 16'h0000, 16'h0F64};
    logic [15:0] vc[4] = '{16'h0005, 16'h0006, 16'h0007, 16'h0000};
    always #5 ref_clk = ~ref_clk;
    ccr_regs #(.DEV_ADDR(7'h2A)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .temp_below_0(temp_below_0), .temp_above_60(temp_above_60),
        .temp_band(temp_band), .vbat_ge_3v0(vbat_ge_3v0), .charge_enable(charge_enable),
        .temp_fault(temp_fault), .band_current_ma(band_current_ma),
        .output_limit_ma(output_limit_ma), .vterm_code(vterm_code), .vterm_mv(vterm_mv),
        .vterm_invalid(vterm_invalid));
    ccr_host #(.DEV(7'h2A)) u_host (.ref_clk(ref_clk), .sda_in(sda), .scl(scl), .sda_pull(pull));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic w(input [7:0] ra, input [7:0] v);
        u_host.wr(7'h2A, ra, v, ok);
        chk(ok, 1'b1);
    endtask
    task automatic r(input [7:0] ra, input [7:0] v);
        u_host.rd(ra, d);
        chk(d, v);
    endtask
    task automatic end_sim;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        step(8);
        rst = 1'b0;
        step(4);
        chk(charge_enable, 1'b1);
        chk(band_current_ma, 16'h0032);
        chk(vterm_mv, 16'h0F64);
        chk(output_limit_ma, 16'h0032);
        chk(sda_out, 1'b0);
        $display("test reset done");
        w(8'h04, 8'h5A);
        r(8'h04, 8'h00);
        w(8'h11, 8'hFF);
        r(8'h11, 8'h01);
        r(8'h04, 8'h00);
        $display("test gate done");
        w(8'h04, 8'hA5);
        w(8'h05, 8'h3C);
        r(8'h04, 8'hA5);
        r(8'h05, 8'h3C);
        u_host.rd2(8'h04, d, d2);
        chk(d, 8'hA5);
        chk(d2, 8'h3C);
        w(8'h02, 8'h6E);
        w(8'h03, 8'hF8);
        r(8'h02, 8'h6E);
        r(8'h03, 8'hF8);
        w(8'h06, 8'hC3);
        r(8'h06, 8'hC3);
        // walk the bands: current and termination follow the band
        for (int b = 0; b < 4; b++) begin
            temp_band = b[1:0];
            step(4);
            chk(band_current_ma, cur[b]);
            chk(vterm_mv, vt[b]);
            chk(vterm_invalid, b == 2);
            chk(vterm_code, vc[b]);
        end
        chk(output_limit_ma, 16'h0064);
        vbat_ge_3v0 = 1'b1;
        step(4);
        chk(output_limit_ma, 16'h0172);
        $display("test bands done");
        temp_band = 2'h1;
        // every current code through the nominal field
        for (int c = 0; c < 16; c++) begin
            w(8'h04, {~c[3:0], c[3:0]});
            step(4);
            chk(band_current_ma, (c == 0) ? 16'h0032 : 16'(c * 100));
        end
        $display("test codes done");
        for (int f = 0; f < 2; f++) begin
            {temp_above_60, temp_below_0} = f ? 2'b10 : 2'b01;
            step(4);
            chk(temp_fault, 1'b1);
            chk(charge_enable, 1'b0);
            {temp_above_60, temp_below_0} = 2'b00;
            step(4);
            chk(charge_enable, 1'b1);
            chk(temp_fault, 1'b0);
        end
        $display("test fault done");
        u_host.wr(7'h2B, 8'h04, 8'h00, ok);
        chk(ok, 1'b0);
        r(8'h04, 8'h0F);
        w(8'h20, 8'h55);
        r(8'h20, 8'h00);
        w(8'h11, 8'h00);
        r(8'h04, 8'h00);
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        step(4);
        r(8'h04, 8'h00);
        $display("test misc done");
        end_sim();
    end
endmodule // charge_current_config_regs_tb_top
